// ---- core/lrx_params.svh ----
// Timing, width and code constants for the link recovery exit block.
`ifndef LRX_PARAMS_SVH
`define LRX_PARAMS_SVH

// Clock rate in kHz (125 MHz port clock).
`define LRX_CLK_KHZ        125000
// Recovery path limit in milliseconds.
`define LRX_PATH_MS        5
// Cycles in one millisecond tick.
`define LRX_MS_CYCLES      (`LRX_CLK_KHZ)
// Short acknowledge timeout in microseconds, inside the 100 to 200 window.
`define LRX_ACK_SHORT_US   150
// Short acknowledge timeout as clock cycles.
`define LRX_ACK_SHORT_CYC  ((`LRX_ACK_SHORT_US * `LRX_CLK_KHZ) / 1000)
// Sequence counter modulus masks for normal and extended operation.
`define LRX_MASK_NORMAL    8'h03
`define LRX_MASK_EXT       8'hFF
// Alert code width.
`define LRX_ALERT_W        8
// Alert code used for a ready-state timeout exit.
`define LRX_ALERT_READY_TO 8'h0B
// Alert code used for a disabled-state wait timeout exit.
`define LRX_ALERT_DIS_TO   8'h0A
// Alert code used when a path supervisor overruns.
`define LRX_ALERT_PATH_TO  8'h0C

`endif

// ---- core/lrx_pkg.sv ----
// Types shared by the link recovery exit block.
package lrx_pkg;

    // Recovery and exit sequence states, one-hot.
    typedef enum logic [11:0] {
        LRX_IDLE      = 12'h001,
        LRX_TXWAIT    = 12'h002,
        LRX_RSTWAIT   = 12'h004,
        LRX_DISABLED  = 12'h008,
        LRX_ENABLED   = 12'h010,
        LRX_READY     = 12'h020,
        LRX_EX_OPER   = 12'h040,
        LRX_EX_EXT    = 12'h080,
        LRX_EX_PRIV   = 12'h100,
        LRX_EX_ALERT  = 12'h200,
        LRX_EX_RST    = 12'h400,
        LRX_RETX      = 12'h800
    } lrx_state_t;

    // Events seen on the link by the receiver and transmitter.
    typedef struct packed {
        logic codeViolation;   // Transmitter saw a code violation.
        logic frameActive;     // A frame is being sent.
        logic txBusy;          // Transmission still in progress.
        logic resetFrameRx;    // Link reset frame received.
        logic disableSeen;     // Remote disable_character detected.
        logic flagSeen;        // Flag character received.
        logic exitFail;        // Other recovery step asks for failed exit.
    } lrx_link_evt_t;

    // Port control outputs.
    typedef struct packed {
        logic abortFrame;      // Abort the frame in flight.
        logic checkState;      // Port is in Check state.
        logic sendResetFrame;  // Send own link reset frame.
        logic disabledState;   // Port is Disabled.
        logic enabledState;    // Port is Enabled.
        logic readyState;      // Port is Ready.
        logic restartPort;     // Run the normal restart sequence.
    } lrx_port_ctl_t;

endpackage

// ---- core/lrx_link_recovery.sv ----
// Link recovery timing supervisor and unsuccessful-exit sequencer.
`include "lrx_params.svh"

module lrx_link_recovery #(
    parameter int MS_CYCLES = `LRX_MS_CYCLES,  // Cycles per millisecond tick.
    parameter int PATH_MS   = `LRX_PATH_MS,    // Milliseconds per path.
    parameter int PTR_W     = 8,               // Send slot pointer width.
    parameter int SEQ_W     = 8                // Sequence counter width.
) (
    input  wire logic                    clk,
    input  wire logic                    srst,
    input  wire lrx_pkg::lrx_link_evt_t  linkEvt,
    input  wire logic                    extCapable,
    input  wire logic [SEQ_W-1:0]        transmitSequenceCount,
    input  wire logic [SEQ_W-1:0]        remoteReceiveSequenceCount,
    input  wire logic [PTR_W-1:0]        sendSlotPointer,
    input  wire logic [`LRX_ALERT_W-1:0] exitAlertCode,
    output lrx_pkg::lrx_port_ctl_t       portCtl,
    output logic                         linkUp,
    output logic                         extDistanceOn,
    output logic [15:0]                  ackTimeoutCycles,
    output logic                         privilegedMode,
    output logic                         dropAppFrames,
    output logic                         alertValid,
    output logic [`LRX_ALERT_W-1:0]      alertCode,
    output logic                         retransmitStart,
    output logic [PTR_W-1:0]             retransmitPointer,
    output logic [SEQ_W-1:0]             unreceivedCount,
    output logic                         pathOverrun
);
    import lrx_pkg::*;

    // ****************************************************************
    // Millisecond timebase
    // ****************************************************************

    // Free-running cycle divider giving one tick per millisecond.
    logic [31:0] msDiv_reg, msDiv_next;
    logic        msTick;

    // Divider next value; the tick fires on the last count.
    always_comb begin
        msTick    = (msDiv_reg == 32'(MS_CYCLES - 1));
        msDiv_next = msTick ? 32'h0000_0000 : msDiv_reg + 32'h0000_0001;
    end

    // Divider register.
    always_ff @(posedge clk) begin
        if (srst) begin
            msDiv_reg <= 32'h0000_0000;
        end else begin
            msDiv_reg <= msDiv_next;
        end
    end

    // ****************************************************************
    // Recovery sequencer
    // ****************************************************************

    lrx_state_t             state_reg, state_next;       // Sequencer state.
    logic [7:0]             msLeft_reg, msLeft_next;     // Path budget left.
    logic                   resetSent_reg, resetSent_next; // Own reset frame out.
    logic                   resetRcvd_reg, resetRcvd_next; // Remote reset frame in.
    logic                   linkUp_reg, linkUp_next;
    logic                   ext_reg, ext_next;
    logic [15:0]            ackTo_reg, ackTo_next;
    logic                   priv_reg, priv_next;
    logic                   alertV_reg, alertV_next;
    logic [`LRX_ALERT_W-1:0] alertC_reg, alertC_next;
    logic [`LRX_ALERT_W-1:0] pendCode_reg, pendCode_next; // Code of the exit taken.
    logic                   retx_reg, retx_next;
    logic [PTR_W-1:0]       retxPtr_reg, retxPtr_next;
    logic [SEQ_W-1:0]       unrcv_reg, unrcv_next;
    logic                   overrun_reg, overrun_next;
    lrx_port_ctl_t          ctl_reg, ctl_next;
    logic [SEQ_W-1:0]       seqMask;                     // Modulus mask.
    logic [SEQ_W-1:0]       seqDiff;                     // Unreceived frames.
    logic                   budgetOut;                   // Path budget spent.

    // Next-state logic. Each 5 ms path reloads the budget on entry, except a receive-to-send path whose
    // remote frame lands with the violation; when the budget runs out the port exits unsuccessfully, with pathOverrun raised only in
    // TXWAIT and RSTWAIT, so a stuck remote cannot hold recovery open forever.
    always_comb begin
        state_next     = state_reg;
        msLeft_next    = msLeft_reg;
        resetSent_next = resetSent_reg;
        resetRcvd_next = resetRcvd_reg | linkEvt.resetFrameRx;
        linkUp_next    = linkUp_reg;
        ext_next       = ext_reg;
        ackTo_next     = ackTo_reg;
        priv_next      = priv_reg;
        alertV_next    = 1'b0;
        alertC_next    = alertC_reg;
        pendCode_next  = pendCode_reg;
        retx_next      = 1'b0;
        retxPtr_next   = retxPtr_reg;
        unrcv_next     = unrcv_reg;
        overrun_next   = 1'b0;
        ctl_next       = ctl_reg;
        ctl_next.abortFrame     = 1'b0;
        ctl_next.sendResetFrame = 1'b0;
        ctl_next.restartPort    = 1'b0;
        seqMask   = ext_reg ? SEQ_W'(`LRX_MASK_EXT) : SEQ_W'(`LRX_MASK_NORMAL);
        seqDiff   = (transmitSequenceCount - remoteReceiveSequenceCount) & seqMask;
        budgetOut = (msLeft_reg == 8'h00);
        if (msTick && !budgetOut) begin
            msLeft_next = msLeft_reg - 8'h01;
        end
        unique case (state_reg)
            LRX_IDLE, LRX_READY: begin
                if (linkEvt.codeViolation && linkEvt.frameActive) begin
                    ctl_next.abortFrame = 1'b1;
                    ctl_next.checkState = 1'b1;
                    ctl_next.readyState = 1'b0;
                    resetSent_next      = 1'b0;
                    // A remote reset frame landing in this same cycle still counts.
                    resetRcvd_next      = linkEvt.resetFrameRx;
                    state_next          = LRX_TXWAIT;
                // A reset frame from the remote also opens recovery.
                end else if (linkEvt.resetFrameRx) begin
                    ctl_next.checkState = 1'b1;
                    ctl_next.readyState = 1'b0;
                    resetSent_next      = 1'b0;
                    resetRcvd_next      = 1'b1;
                    msLeft_next         = 8'(PATH_MS);
                    state_next          = LRX_TXWAIT;
                end
            end
            LRX_TXWAIT: begin
                if (!linkEvt.txBusy) begin
                    ctl_next.sendResetFrame = 1'b1;
                    resetSent_next          = 1'b1;
                    unrcv_next              = seqDiff;
                    msLeft_next             = 8'(PATH_MS);
                    state_next              = LRX_RSTWAIT;
                end else if (resetRcvd_reg && budgetOut) begin
                    overrun_next  = 1'b1;
                    pendCode_next = `LRX_ALERT_PATH_TO;
                    state_next    = LRX_EX_OPER;
                end else if (linkEvt.resetFrameRx && !resetRcvd_reg) begin
                    // The receive-to-send path starts when the remote frame lands; a frame that lands
                    // with the violation skips this reload, so a stale budget can cut that path short.
                    msLeft_next = 8'(PATH_MS);
                end
            end
            LRX_RSTWAIT: begin
                if (resetRcvd_reg) begin
                    ctl_next.disabledState = 1'b1;
                    ctl_next.checkState    = 1'b0;
                    msLeft_next            = 8'(PATH_MS);
                    state_next             = LRX_DISABLED;
                end else if (linkEvt.resetFrameRx) begin
                    // An arrival wins over a budget that runs out in the same cycle.
                    msLeft_next = 8'(PATH_MS);
                end else if (budgetOut) begin
                    overrun_next  = 1'b1;
                    pendCode_next = `LRX_ALERT_PATH_TO;
                    state_next    = LRX_EX_OPER;
                end
            end
            LRX_DISABLED: begin
                if (linkEvt.disableSeen) begin
                    ctl_next.disabledState = 1'b0;
                    ctl_next.enabledState  = 1'b1;
                    msLeft_next            = 8'(PATH_MS);
                    state_next             = LRX_ENABLED;
                end else if (budgetOut) begin
                    pendCode_next = `LRX_ALERT_DIS_TO;
                    state_next    = LRX_EX_OPER;
                end
            end
            LRX_ENABLED: begin
                if (linkEvt.flagSeen) begin
                    ctl_next.enabledState = 1'b0;
                    ctl_next.readyState   = 1'b1;
                    state_next            = LRX_RETX;
                end else if (budgetOut) begin
                    pendCode_next = `LRX_ALERT_READY_TO;
                    state_next    = LRX_EX_OPER;
                end
            end
            LRX_RETX: begin
                retx_next    = 1'b1;
                retxPtr_next = sendSlotPointer - PTR_W'(unrcv_reg);
                state_next   = LRX_READY;
            end
            LRX_EX_OPER: begin
                linkUp_next = 1'b0;
                state_next  = LRX_EX_EXT;
            end
            LRX_EX_EXT: begin
                if (extCapable) begin
                    ext_next   = 1'b0;
                    ackTo_next = 16'(`LRX_ACK_SHORT_CYC);
                end
                state_next = LRX_EX_PRIV;
            end
            LRX_EX_PRIV: begin
                priv_next  = 1'b1;
                state_next = LRX_EX_ALERT;
            end
            LRX_EX_ALERT: begin
                alertV_next = 1'b1;
                alertC_next = pendCode_reg;
                state_next  = LRX_EX_RST;
            end
            LRX_EX_RST: begin
                ctl_next              = '0;
                ctl_next.restartPort  = 1'b1;
                state_next            = LRX_IDLE;
            end
            default: begin
                state_next = LRX_IDLE;
            end
        endcase
        // An unsuccessful exit requested by another recovery step.
        if (linkEvt.exitFail && (state_reg inside {LRX_TXWAIT, LRX_RSTWAIT,
                                                   LRX_DISABLED, LRX_ENABLED})) begin
            pendCode_next = exitAlertCode;
            state_next    = LRX_EX_OPER;
        end
    end

    // Sequencer registers. After reset the link is up and Ready, with extended
    // distance on whenever the port supports it; only an exit turns it off.
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg     <= LRX_READY;
            msLeft_reg    <= 8'h00;
            resetSent_reg <= 1'b0;
            resetRcvd_reg <= 1'b0;
            linkUp_reg    <= 1'b1;
            ext_reg       <= extCapable;
            ackTo_reg     <= 16'(`LRX_ACK_SHORT_CYC);
            priv_reg      <= 1'b0;
            alertV_reg    <= 1'b0;
            alertC_reg    <= 8'h00;
            pendCode_reg  <= 8'h00;
            retx_reg      <= 1'b0;
            retxPtr_reg   <= '0;
            unrcv_reg     <= '0;
            overrun_reg   <= 1'b0;
            ctl_reg       <= '{readyState: 1'b1, default: 1'b0};
        end else begin
            state_reg     <= state_next;
            msLeft_reg    <= msLeft_next;
            resetSent_reg <= resetSent_next;
            resetRcvd_reg <= resetRcvd_next;
            linkUp_reg    <= linkUp_next;
            ext_reg       <= ext_next;
            ackTo_reg     <= ackTo_next;
            priv_reg      <= priv_next;
            alertV_reg    <= alertV_next;
            alertC_reg    <= alertC_next;
            pendCode_reg  <= pendCode_next;
            retx_reg      <= retx_next;
            retxPtr_reg   <= retxPtr_next;
            unrcv_reg     <= unrcv_next;
            overrun_reg   <= overrun_next;
            ctl_reg       <= ctl_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************

    // All outputs come straight from registers.
    assign portCtl           = ctl_reg;
    assign linkUp            = linkUp_reg;
    assign extDistanceOn     = ext_reg;
    assign ackTimeoutCycles  = ackTo_reg;
    assign privilegedMode    = priv_reg;
    assign dropAppFrames     = priv_reg;
    assign alertValid        = alertV_reg;
    assign alertCode         = alertC_reg;
    assign retransmitStart   = retx_reg;
    assign retransmitPointer = retxPtr_reg;
    assign unreceivedCount   = unrcv_reg;
    assign pathOverrun       = overrun_reg;

endmodule

// ---- verification/lrx_link_recovery_props.sv ----
// Concurrent checks on the ports of the link recovery exit block.
module lrx_link_recovery_props (
    input wire logic                   clk,
    input wire logic                   srst,
    input wire lrx_pkg::lrx_link_evt_t linkEvt,
    input wire lrx_pkg::lrx_port_ctl_t portCtl,
    input wire logic                   linkUp,
    input wire logic                   extDistanceOn,
    input wire logic [15:0]            ackTimeoutCycles,
    input wire logic                   privilegedMode,
    input wire logic                   dropAppFrames,
    input wire logic                   alertValid
);
    timeunit 1ns;
    timeprecision 1ps;
    import lrx_pkg::*;
    // One clock domain, so one default clock and one disable condition.
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    a_viol_abort:
        assert property (linkEvt.codeViolation && linkEvt.frameActive && portCtl.readyState
            |=> portCtl.abortFrame && portCtl.checkState) else $error("no abort after violation");
    a_tx_idle_first:
        assert property (portCtl.sendResetFrame |-> !$past(linkEvt.txBusy))
            else $error("reset frame sent while busy");
    a_enable_step:
        assert property (portCtl.disabledState && linkEvt.disableSeen |=> portCtl.enabledState)
            else $error("enabled state missing");
    a_ready_step:
        assert property (portCtl.enabledState && linkEvt.flagSeen |=> portCtl.readyState)
            else $error("ready state missing");
    a_exit_order:
        assert property ($fell(linkUp) |-> !privilegedMode ##2 privilegedMode && !alertValid
            ##1 alertValid ##1 portCtl.restartPort) else $error("exit steps out of order");
    a_link_first:
        assert property (privilegedMode |-> !linkUp) else $error("privileged while link up");
    a_ext_fallback:
        assert property ($fell(linkUp) |-> ##1 !extDistanceOn
            && ackTimeoutCycles inside {[16'h30D4:16'h61A8]}) else $error("ack timeout wrong");
    a_priv_sticky:
        assert property (privilegedMode |=> privilegedMode && dropAppFrames)
            else $error("application frames not dropped");
    a_alert_then_restart:
        assert property (alertValid |-> privilegedMode ##1 portCtl.restartPort)
            else $error("no restart after alert");

    c_exit: cover property ($fell(linkUp));
    c_ready: cover property (portCtl.enabledState && linkEvt.flagSeen);
    c_violation: cover property (linkEvt.codeViolation && linkEvt.frameActive);
endmodule

bind lrx_link_recovery lrx_link_recovery_props u_props (
    .clk(clk), .srst(srst), .linkEvt(linkEvt), .portCtl(portCtl), .linkUp(linkUp),
    .extDistanceOn(extDistanceOn), .ackTimeoutCycles(ackTimeoutCycles),
    .privilegedMode(privilegedMode), .dropAppFrames(dropAppFrames), .alertValid(alertValid)
);

// ---- verification/lrx_remote_port.sv ----
// Behavioural remote port answering this port's recovery steps from the far side of the link.
module lrx_remote_port (
    input  wire logic                   clk,
    input  wire logic                   srst,
    input  wire lrx_pkg::lrx_port_ctl_t portCtl,
    input  wire logic                   kick,
    input  wire logic                   mute,
    input  wire logic [7:0]             replyDelay,
    output logic                        resetFrameRx,
    output logic                        disableSeen,
    output logic                        flagSeen
);
    timeunit 1ns;
    timeprecision 1ps;
    import lrx_pkg::*;
    logic [7:0] cntReg;  // Cycles left before our answering reset frame.
    logic       pendReg; // An answering reset frame is owed.
    logic       sentReg; // Our reset frame already went out in this recovery.

    // A slow reply stresses the later-of rule; kick lets us start recovery ourselves.
    always_ff @(posedge clk) begin
        resetFrameRx <= 1'b0;
        if (srst) begin
            pendReg <= 1'b0;
            sentReg <= 1'b0;
            cntReg  <= 8'h00;
        end else if (kick) begin
            resetFrameRx <= 1'b1;
            sentReg      <= 1'b1;
        end else if (portCtl.sendResetFrame && !sentReg) begin
            pendReg <= 1'b1;
            cntReg  <= replyDelay;
        end else if (pendReg && cntReg == 8'h00) begin
            resetFrameRx <= 1'b1;
            pendReg      <= 1'b0;
            sentReg      <= 1'b1;
        end else if (pendReg) begin
            cntReg <= cntReg - 8'h01;
        end else if (portCtl.enabledState) begin
            sentReg <= 1'b0;
        end
        disableSeen <= !srst && portCtl.disabledState;
        flagSeen <= !srst && portCtl.enabledState && !mute;
    end
endmodule

// ---- verification/tb.sv ----
// Self-checking testbench for the link recovery exit block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import lrx_pkg::*;
    logic          clk = 1'b0;
    logic          srst;
    logic          codeViolation, frameActive, txBusy, exitFail, kick, mute, extCapable;
    logic          resetFrameRx, disableSeen, flagSeen;
    logic [7:0]    transmit_sequence_count, receive_sequence_count, ptr, exitCode, replyDelay, alertCode, retxPtr, unrxCount;
    lrx_port_ctl_t portCtl;
    logic          linkUp, extOn, privMode, dropApp, alertValid, retxStart, pathOverrun;
    logic [15:0]   ackCycles;
    logic [7:0]    watch;  // Events waited on, one bit each.
    int            failCount = 0;
    int            nChecks = 0;
    lrx_link_evt_t linkEvt;

    assign linkEvt = {codeViolation, frameActive, txBusy, resetFrameRx, disableSeen, flagSeen,
                      exitFail};
    assign watch = {pathOverrun, alertValid, retxStart, portCtl.readyState, portCtl.enabledState,
                    portCtl.disabledState, portCtl.sendResetFrame, !linkUp};
    always #4 clk = ~clk;

    // A 10-cycle tick keeps each 5 ms path at 50 cycles.
    lrx_link_recovery #(.MS_CYCLES(10)) u_dut (
        .clk(clk), .srst(srst), .linkEvt(linkEvt), .extCapable(extCapable),
        .transmitSequenceCount(transmit_sequence_count), .remoteReceiveSequenceCount(receive_sequence_count), .sendSlotPointer(ptr),
        .exitAlertCode(exitCode), .portCtl(portCtl), .linkUp(linkUp), .extDistanceOn(extOn),
        .ackTimeoutCycles(ackCycles), .privilegedMode(privMode), .dropAppFrames(dropApp),
        .alertValid(alertValid), .alertCode(alertCode), .retransmitStart(retxStart),
        .retransmitPointer(retxPtr), .unreceivedCount(unrxCount), .pathOverrun(pathOverrun));
    lrx_remote_port u_remote (
        .clk(clk), .srst(srst), .portCtl(portCtl), .kick(kick), .mute(mute),
        .replyDelay(replyDelay), .resetFrameRx(resetFrameRx), .disableSeen(disableSeen),
        .flagSeen(flagSeen));

    task automatic finalReport();
        $display("checks %0d mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        nChecks++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Bounded wait on one watch bit; a hang ends the run.
    task automatic waitBit(input int b, input int limit, output int cyc);
        cyc = 0;
        while (watch[b] !== 1'b1) begin
            @(negedge clk);
            cyc++;
            if (cyc > limit) begin
                check($sformatf("wait on bit %0d", b), 16'h0000, 16'h0001);
                finalReport();
            end
        end
    endtask
    // A code violation in mid-frame, with the transmitter still busy.
    task automatic violate();
        frameActive = 1'b1;
        txBusy = 1'b1;
        codeViolation = 1'b1;
        @(negedge clk);
        codeViolation = 1'b0;
    endtask

    // Violation, slow remote, full recovery; extended mode keeps a difference of 4.
    task automatic scenViolation();
        int cyc;
        transmit_sequence_count = 8'h05;
        receive_sequence_count = 8'h01;
        replyDelay = 8'h14;
        violate();
        check("abort and check", {portCtl.abortFrame, portCtl.checkState}, 16'h3);
        repeat (4) @(negedge clk);
        check("reset frame while busy", portCtl.sendResetFrame, 16'h0);
        txBusy = 1'b0;
        frameActive = 1'b0;
        waitBit(1, 5, cyc);
        waitBit(2, 30, cyc);
        check("disabled after late reply", 16'(cyc <= 26), 16'h1);
        check("unreceived modulo 256", unrxCount, 16'h04);
        waitBit(3, 50, cyc);
        waitBit(4, 50, cyc);
        waitBit(5, 3, cyc);
        check("retransmit pointer", retxPtr, 16'h26);
        repeat (3) @(negedge clk);
    endtask
    // Remote starts recovery, then never sends a flag: ready timeout exit.
    task automatic scenReadyTimeout();
        int cyc;
        transmit_sequence_count = 8'h02;
        receive_sequence_count = 8'h03;
        replyDelay = 8'h00;
        mute = 1'b1;
        kick = 1'b1;
        @(negedge clk);
        kick = 1'b0;
        waitBit(1, 60, cyc);
        check("own reset frame in time", 16'(cyc <= 50), 16'h1);
        waitBit(2, 50, cyc);
        check("unreceived wraps", unrxCount, 16'hFF);
        waitBit(0, 120, cyc);
        check("privileged before link down", privMode, 16'h0);
        @(negedge clk);
        check("fallback", extOn, 16'h0);
        check("short ack timeout", ackCycles, 16'h493E);
        @(negedge clk);
        check("privileged and dropping", {privMode, dropApp}, 16'h3);
        @(negedge clk);
        check("ready timeout alert", {alertValid, alertCode}, 16'h10B);
        @(negedge clk);
        check("restart only", portCtl, 16'h01);
        mute = 1'b0;
        repeat (3) @(negedge clk);
    endtask
    // Extended mode is off after the first exit, so the difference wraps modulo 4;
    // then the enclosing recovery asks for a failed exit with its own code.
    task automatic scenExitRequest();
        int cyc;
        exitCode = 8'h5C;
        violate();
        txBusy = 1'b0;
        frameActive = 1'b0;
        waitBit(1, 5, cyc);
        check("unreceived modulo 4", unrxCount, 16'h03);
        exitFail = 1'b1;
        @(negedge clk);
        exitFail = 1'b0;
        waitBit(6, 10, cyc);
        check("requested alert code", alertCode, 16'h5C);
        repeat (3) @(negedge clk);
    endtask
    // Remote reset frame lands while the transmitter never finishes: the
    // supervisor must cut the path off after a full budget, not at once.
    task automatic scenOverrun();
        int cyc;
        violate();
        kick = 1'b1;
        @(negedge clk);
        kick = 1'b0;
        waitBit(7, 60, cyc);
        check("overrun within budget", 16'(cyc >= 43 && cyc <= 52), 16'h1);
        waitBit(6, 10, cyc);
        check("overrun alert code", alertCode, 16'h0C);
        txBusy = 1'b0;
        frameActive = 1'b0;
    endtask

    initial begin
        srst = 1'b1;
        {codeViolation, frameActive, txBusy, exitFail, kick, mute} = 6'h00;
        extCapable = 1'b1;
        {transmit_sequence_count, receive_sequence_count, exitCode, replyDelay} = 32'h0;
        ptr = 8'h2A;
        repeat (3) @(negedge clk);
        srst = 1'b0;
        check("ready after reset", {portCtl, linkUp, privMode}, 16'h0A);
        check("ack timeout after reset", ackCycles, 16'h493E);
        check("extended mode after reset", extOn, 16'h1);
        scenViolation();
        scenReadyTimeout();
        scenExitRequest();
        scenOverrun();
        finalReport();
    end
endmodule
